/* design/rsq_pkg.sv */
`default_nettype none
package rsq_pkg;

    // ------------------------------------------------------------
    // Reset sources
    // ------------------------------------------------------------
    localparam int          SRC_N        = 8;
    localparam int          SRC_POR      = 0;
    localparam int          SRC_PIN      = 1;
    localparam int          SRC_CMP      = 2;
    localparam int          SRC_SW       = 3;
    localparam int          SRC_VMON     = 4;
    localparam int          SRC_WDT      = 5;
    localparam int          SRC_MCD      = 6;
    localparam int          SRC_FLASH    = 7;
    localparam logic [7:0]  SRC_PIN_MASK = 8'h11;

    // ------------------------------------------------------------
    // Boot vector and flash layout
    // ------------------------------------------------------------
    localparam int          ADDR_W       = 16;
    localparam logic [7:0]  SIG_PRESENT  = 8'hA5;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [15:0] LOCK_ADDR    = 16'hFBFF;
    localparam logic [15:0] SIG_ADDR     = LOCK_ADDR - 16'h0001;
    localparam logic [15:0] SEC_PAGE     = 16'hFA00;
    localparam logic [15:0] BOOT_VECTOR  = SEC_PAGE;

    // ------------------------------------------------------------
    // Port, watchdog and clock defaults
    // ------------------------------------------------------------
    localparam int          PORT_W       = 8;
    localparam logic [7:0]  PORT_LATCH_R = 8'hFF;
    localparam logic [7:0]  PORT_OD_R    = 8'hFF;
    localparam logic [7:0]  PORT_PU_R    = 8'hFF;
    localparam int          DAC_W        = 12;
    localparam logic [11:0] DAC_R        = 12'h000;
    localparam logic [1:0]  VREF_R       = 2'h0;
    localparam logic [2:0]  WDT_IVL_MAX  = 3'h7;
    localparam logic [1:0]  CLKSEL_OSC   = 2'h0;
    localparam int          FLASH_LAT    = 2;

    typedef enum logic [3:0] {
        ST_RESET = 4'h1,
        ST_FETCH = 4'h2,
        ST_WAIT  = 4'h4,
        ST_RUN   = 4'h8
    } rsq_state_t;

endpackage
`default_nettype wire

/* design/rsq_src_gate.sv */
`timescale 1ns/1ps
`default_nettype none
module rsq_src_gate
    import rsq_pkg::*;
(
    input  wire logic             CLK,
    input  wire logic             RST_N,
    input  wire logic [SRC_N-1:0] SRC_REQ,
    input  wire logic [SRC_N-1:0] SRC_EN,
    output logic                  ANY_Q,
    output logic                  PIN_DRV_Q,
    output logic                  POR_SEEN_Q
);
    logic [SRC_N-1:0] act;

    // Power-on is never maskable
    assign act = SRC_REQ & (SRC_EN | (SRC_N'(1) << SRC_POR));

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            ANY_Q      <= 1'b1;
            PIN_DRV_Q  <= 1'b1;
            POR_SEEN_Q <= 1'b1;
        end
        else
        begin
            ANY_Q      <= |act; // R16
            PIN_DRV_Q  <= |(act & SRC_PIN_MASK);
            POR_SEEN_Q <= act[SRC_POR];
        end
    end
endmodule
`default_nettype wire

/* design/rsq_sig_read.sv */
`timescale 1ns/1ps
`default_nettype none
module rsq_sig_read
    import rsq_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic              RST_N,
    input  wire logic              START,
    input  wire logic [7:0]        RDATA,
    output logic                   DONE_Q,
    output logic                   PRESENT_Q
);
    logic [1:0] cnt_q;

    // ------------------------------------------------------------
    // Fixed-latency flash read of the signature byte
    // ------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (!RST_N || START)
        begin
            cnt_q  <= 2'h0;
            DONE_Q <= 1'b0;
        end
        else if (!DONE_Q)
        begin
            if (cnt_q == 2'(FLASH_LAT))
                DONE_Q <= 1'b1;
            else
                cnt_q <= cnt_q + 2'h1;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            PRESENT_Q <= 1'b0;
        else if (!DONE_Q && cnt_q == 2'(FLASH_LAT))
            PRESENT_Q <= (RDATA == SIG_PRESENT); // R11
    end
endmodule
`default_nettype wire

/* design/rsq_top.sv */
// How it works
// R1: Any active reset source halts the core until reset exits.
// R2: Module registers take reset values, except power-on-only bits.
// R3: Reset disables interrupts and stops timers.
// R4: Data memory is never written or cleared by reset.
// R5: Port latches reset to one, open-drain, weak pull-ups on.
// R6: Retention options keep ports, converters and reference except on power-on.
// R7: Supply-monitor and power-on resets drive the external pin low.
// R8: Exit clears program counter and selects the on-chip oscillator.
// R9: Watchdog is enabled and counting after reset exit.
// R10: Eight reset sources are accepted.
// R11: Byte below the lock byte is signature; A5 means bootloader.
// R12: Bootloader present means fetch starts at the bootloader vector.
// R13: Otherwise fetch starts at address zero.
// R14: Bootloader vector lies in the last flash page.
// R15: Watchdog interval defaults to maximum after any reset.
// R16: Internal reset is OR of enabled sources, held until all release.
// R17: Signature is read during exit before the first fetch.
`timescale 1ns/1ps
`default_nettype none
module rsq_top
    import rsq_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic              RST_N,
    input  wire logic [SRC_N-1:0]  SRC_REQ,
    input  wire logic [SRC_N-1:0]  SRC_EN,
    input  wire logic              RET_PORT,
    input  wire logic              RET_DAC,
    input  wire logic              RET_VREF,
    input  wire logic [PORT_W-1:0] SW_PORT_LATCH,
    input  wire logic [PORT_W-1:0] SW_PORT_OD,
    input  wire logic [PORT_W-1:0] SW_PORT_PU,
    input  wire logic [DAC_W-1:0]  SW_DAC,
    input  wire logic [1:0]        SW_VREF,
    input  wire logic [7:0]        FLASH_RDATA,
    output logic                   CORE_HALT,
    output logic                   MOD_RESET,
    output logic                   IRQ_EN,
    output logic                   TIMER_RUN,
    output logic                   RAM_WE_BLOCK,
    output logic [PORT_W-1:0]      PORT_LATCH,
    output logic [PORT_W-1:0]      PORT_OD,
    output logic [PORT_W-1:0]      PORT_PU,
    output logic [DAC_W-1:0]       DAC_OUT,
    output logic [1:0]             VREF_SEL,
    output logic                   EXT_RESET_PIN_N_O,
    output logic                   EXT_RESET_PIN_N_OE,
    output logic [ADDR_W-1:0]      PC_START,
    output logic                   PC_LOAD,
    output logic [1:0]             CLK_SEL,
    output logic                   WDT_EN,
    output logic [2:0]             WDT_IVL,
    output logic                   FLASH_RD,
    output logic [ADDR_W-1:0]      FLASH_ADDR,
    output logic                   BOOT_PRESENT
);
    // ------------------------------------------------------------
    // Source gathering and signature reader
    // ------------------------------------------------------------
    logic       any_rst;
    logic       pin_drv;
    logic       por_seen;
    logic       sig_done;
    logic       sig_present;
    logic       sig_start;
    rsq_state_t st_q;
    rsq_state_t st_d;
    logic       por_ret_q;

    rsq_src_gate u_gate (
        .CLK        (CLK),
        .RST_N      (RST_N),
        .SRC_REQ    (SRC_REQ), // R10
        .SRC_EN     (SRC_EN),
        .ANY_Q      (any_rst),
        .PIN_DRV_Q  (pin_drv),
        .POR_SEEN_Q (por_seen)
    );

    assign sig_start = (st_q == ST_RESET) && !any_rst;

    rsq_sig_read u_sig (
        .CLK       (CLK),
        .RST_N     (RST_N),
        .START     (sig_start), // R17
        .RDATA     (FLASH_RDATA),
        .DONE_Q    (sig_done),
        .PRESENT_Q (sig_present)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            ST_RESET: if (!any_rst) st_d = ST_FETCH;
            ST_FETCH: st_d = ST_WAIT;
            ST_WAIT:  if (sig_done) st_d = ST_RUN;
            ST_RUN:   st_d = ST_RUN;
            default:  st_d = ST_RESET;
        endcase
        if (any_rst)
            st_d = ST_RESET; // R16
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            st_q <= ST_RESET;
        else
            st_q <= st_d;
    end

    // Power-on flag stays until the next exit, so a POR that overlapped
    // any other source still overrides retention.
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            por_ret_q <= 1'b1;
        else if (por_seen)
            por_ret_q <= 1'b1;
        else if (st_q == ST_RUN)
            por_ret_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // Core, module, interrupt and timer control
    // ------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            CORE_HALT    <= 1'b1;
            MOD_RESET    <= 1'b1;
            IRQ_EN       <= 1'b0;
            TIMER_RUN    <= 1'b0;
            RAM_WE_BLOCK <= 1'b1;
        end
        else
        begin
            CORE_HALT    <= (st_d != ST_RUN); // R1
            MOD_RESET    <= (st_d == ST_RESET); // R2
            IRQ_EN       <= 1'b0; // R3
            TIMER_RUN    <= 1'b0; // R3
            if (st_d == ST_RUN && st_q != ST_RUN)
            begin
                IRQ_EN    <= 1'b0;
                TIMER_RUN <= 1'b0;
            end
            // No clear path to memory exists; only stray writes are fenced
            RAM_WE_BLOCK <= (st_d != ST_RUN); // R4
        end
    end

    // ------------------------------------------------------------
    // Port, converter and reference state
    // ------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            PORT_LATCH <= PORT_LATCH_R; // R5
            PORT_OD    <= PORT_OD_R;
            PORT_PU    <= PORT_PU_R;
            DAC_OUT    <= DAC_R;
            VREF_SEL   <= VREF_R;
        end
        else if (st_q == ST_RUN && st_d == ST_RUN)
        begin
            PORT_LATCH <= SW_PORT_LATCH;
            PORT_OD    <= SW_PORT_OD;
            PORT_PU    <= SW_PORT_PU;
            DAC_OUT    <= SW_DAC;
            VREF_SEL   <= SW_VREF;
        end
        else if (st_d == ST_RESET)
        begin
            if (!RET_PORT || por_seen || por_ret_q) // R6
            begin
                PORT_LATCH <= PORT_LATCH_R; // R5
                PORT_OD    <= PORT_OD_R;
                PORT_PU    <= PORT_PU_R;
            end
            if (!RET_DAC || por_seen || por_ret_q)
                DAC_OUT <= DAC_R; // R6
            if (!RET_VREF || por_seen || por_ret_q)
                VREF_SEL <= VREF_R; // R6
        end
    end

    // ------------------------------------------------------------
    // External reset pin
    // ------------------------------------------------------------
    logic pin_hold_q;

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            pin_hold_q <= 1'b1;
        else if (pin_drv)
            pin_hold_q <= 1'b1;
        else if (st_d == ST_RUN)
            pin_hold_q <= 1'b0;
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            EXT_RESET_PIN_N_O  <= 1'b0;
            EXT_RESET_PIN_N_OE <= 1'b1;
        end
        else
        begin
            EXT_RESET_PIN_N_O  <= 1'b0;
            EXT_RESET_PIN_N_OE <= pin_drv || (pin_hold_q && st_d != ST_RUN); // R7
        end
    end

    // ------------------------------------------------------------
    // Boot vector, clock and watchdog on exit
    // ------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            FLASH_RD   <= 1'b0;
            FLASH_ADDR <= SIG_ADDR;
        end
        else
        begin
            FLASH_RD   <= (st_d == ST_FETCH) || (st_d == ST_WAIT && !sig_done); // R17
            FLASH_ADDR <= SIG_ADDR; // R11
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            PC_START     <= RESET_VECTOR;
            PC_LOAD      <= 1'b0;
            BOOT_PRESENT <= 1'b0;
        end
        else
        begin
            PC_LOAD <= (st_q == ST_WAIT) && sig_done && !any_rst;
            if ((st_q == ST_WAIT) && sig_done && !any_rst)
            begin
                BOOT_PRESENT <= sig_present;
                // Bootloader vector sits in the security page
                PC_START <= sig_present ? BOOT_VECTOR : RESET_VECTOR; // R12 R13 R14
            end
            else if (st_d == ST_RESET)
                PC_START <= RESET_VECTOR; // R8
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            CLK_SEL <= CLKSEL_OSC;
            WDT_EN  <= 1'b0;
            WDT_IVL <= WDT_IVL_MAX;
        end
        else if (st_d == ST_RESET)
        begin
            CLK_SEL <= CLKSEL_OSC; // R8
            WDT_EN  <= 1'b0;
            WDT_IVL <= WDT_IVL_MAX; // R15
        end
        else if (st_d == ST_RUN && st_q != ST_RUN)
            WDT_EN <= 1'b1; // R9
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_exit;
        (st_q == ST_WAIT) && sig_done && !any_rst;
    endsequence

    a_halt_in_reset: assert property (@(posedge CLK) disable iff (!RST_N)
        any_rst |=> CORE_HALT) else $error("core runs during reset"); // R1
    a_port_default: assert property (@(posedge CLK) disable iff (!RST_N)
        (por_seen && st_d == ST_RESET) |=> PORT_LATCH == PORT_LATCH_R
        && PORT_PU == PORT_PU_R) else $error("port not defaulted"); // R5
    a_pin_drive: assert property (@(posedge CLK) disable iff (!RST_N)
        pin_drv |=> EXT_RESET_PIN_N_OE && !EXT_RESET_PIN_N_O)
        else $error("reset pin not driven"); // R7
    a_vec_boot: assert property (@(posedge CLK) disable iff (!RST_N)
        s_exit |=> PC_LOAD && PC_START == (sig_present ? BOOT_VECTOR : RESET_VECTOR))
        else $error("wrong boot vector"); // R12
    a_wdt_on_exit: assert property (@(posedge CLK) disable iff (!RST_N)
        (st_q == ST_RUN && $past(st_q) != ST_RUN) |-> WDT_EN && WDT_IVL == WDT_IVL_MAX)
        else $error("watchdog not on at exit"); // R9
    a_irq_off: assert property (@(posedge CLK) disable iff (!RST_N)
        MOD_RESET |-> !IRQ_EN && !TIMER_RUN) else $error("irq live in reset"); // R3
    a_sig_first: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(PC_LOAD) |-> $past(FLASH_RD, 2)) else $error("fetch before signature"); // R17
    a_hold_release: assert property (@(posedge CLK) disable iff (!RST_N)
        any_rst |=> st_q == ST_RESET ##1 1'b1) else $error("left reset early"); // R16
    a_clk_osc: assert property (@(posedge CLK) disable iff (!RST_N)
        PC_LOAD |-> CLK_SEL == CLKSEL_OSC) else $error("clock not on oscillator"); // R8
endmodule
`default_nettype wire

/* tb/rsq_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rsq_flash_model
    import rsq_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rd,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [7:0]        sig,
    output var  logic [7:0]        rdata
);
    initial rdata = 8'h3C;

    // Bus changes every cycle unless the signature byte is being read,
    // so outside a read it alternates between the last signature read and its complement (3C and C3 before any read)
    always @(posedge clk)
    begin
        if (rd && addr == SIG_ADDR)
            rdata <= sig;
        else
            rdata <= ~rdata;
    end
endmodule
`default_nettype wire

/* tb/reset_entry_and_boot_vector_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module reset_entry_and_boot_vector_tb
    import rsq_pkg::*;
;
    logic             CLK, RST_N, RET_PORT, RET_DAC, RET_VREF, PC_LOAD, WDT_EN;
    logic [7:0]       SRC_REQ, SRC_EN, SW_PORT_LATCH, SW_PORT_OD, SW_PORT_PU, sig;
    logic [7:0]       FLASH_RDATA, PORT_LATCH, PORT_OD, PORT_PU;
    logic [DAC_W-1:0] SW_DAC, DAC_OUT;
    logic [1:0]       SW_VREF, VREF_SEL, CLK_SEL;
    logic             CORE_HALT, MOD_RESET, IRQ_EN, TIMER_RUN, RAM_WE_BLOCK;
    logic             EXT_RESET_PIN_N_O, EXT_RESET_PIN_N_OE, FLASH_RD, BOOT_PRESENT;
    logic [2:0]       WDT_IVL;
    logic [15:0]      PC_START, FLASH_ADDR;
    int               failures, num_checks;

    rsq_top i_dut (.CLK, .RST_N, .SRC_REQ, .SRC_EN, .RET_PORT, .RET_DAC, .RET_VREF,
        .SW_PORT_LATCH, .SW_PORT_OD, .SW_PORT_PU, .SW_DAC, .SW_VREF, .FLASH_RDATA,
        .CORE_HALT, .MOD_RESET, .IRQ_EN, .TIMER_RUN, .RAM_WE_BLOCK, .PORT_LATCH,
        .PORT_OD, .PORT_PU, .DAC_OUT, .VREF_SEL, .EXT_RESET_PIN_N_O,
        .EXT_RESET_PIN_N_OE, .PC_START, .PC_LOAD, .CLK_SEL, .WDT_EN, .WDT_IVL,
        .FLASH_RD, .FLASH_ADDR, .BOOT_PRESENT);

    rsq_flash_model i_flash (.clk(CLK), .rd(FLASH_RD), .addr(FLASH_ADDR), .sig(sig),
        .rdata(FLASH_RDATA));

    always #5 CLK = ~CLK;

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask

    task automatic hit_src(input int i);
        @(posedge CLK);
        SRC_REQ[i] <= 1'b1;
        tick(2);
        chk("halt", 16'h1, CORE_HALT);
        chk("module reset", 16'h1, MOD_RESET);
        chk("irq enable", 16'h0, IRQ_EN);
        chk("timer run", 16'h0, TIMER_RUN);
        chk("ram write block", 16'h1, RAM_WE_BLOCK);
        chk("pin drive", (i == SRC_POR || i == SRC_VMON), EXT_RESET_PIN_N_OE);
        chk("pin level", 16'h0, EXT_RESET_PIN_N_O);
    endtask

    task automatic release_all();
        @(posedge CLK);
        SRC_REQ <= 8'h00;
    endtask

    task automatic wait_exit(input logic [15:0] exp_pc);
        int   n;
        logic rd_seen;
        n = 0;
        rd_seen = 1'b0;
        do
        begin
            tick(1);
            n++;
            if (FLASH_RD === 1'b1)
            begin
                rd_seen = 1'b1;
                chk("flash address", SIG_ADDR, FLASH_ADDR);
            end
            if (PC_LOAD !== 1'b1)
                chk("halt before load", 16'h1, CORE_HALT);
        end
        while (PC_LOAD !== 1'b1 && n < 50);
        // A hang counts once and skips the exit checks; later waits stay bounded
        if (n >= 50)
        begin
            failures++;
            return;
        end
        chk("read before load", 16'h1, rd_seen);
        chk("start address", exp_pc, PC_START);
        chk("boot present", exp_pc == BOOT_VECTOR, BOOT_PRESENT);
        chk("halt after load", 16'h0, CORE_HALT);
        chk("module reset off", 16'h0, MOD_RESET);
        chk("ram write open", 16'h0, RAM_WE_BLOCK);
        chk("pin released", 16'h0, EXT_RESET_PIN_N_OE);
        chk("watchdog on", 16'h1, WDT_EN);
        chk("watchdog interval", WDT_IVL_MAX, WDT_IVL);
        chk("clock select", CLKSEL_OSC, CLK_SEL);
        tick(1);
        chk("load pulse", 16'h0, PC_LOAD);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_power_on();
        tick(3);
        chk("halt in reset", 16'h1, CORE_HALT);
        chk("latch", PORT_LATCH_R, PORT_LATCH);
        chk("open drain", PORT_OD_R, PORT_OD);
        chk("pull up", PORT_PU_R, PORT_PU);
        chk("pin drive", 16'h1, EXT_RESET_PIN_N_OE);
        chk("interval", WDT_IVL_MAX, WDT_IVL);
        @(posedge CLK);
        RST_N <= 1'b1;
        wait_exit(BOOT_VECTOR);
        $display("test power_on done");
    endtask

    // Odd sources see a signature one bit away from the present code
    task automatic t_sources();
        for (int i = 0; i < SRC_N; i++)
        begin
            sig = i[0] ? (SIG_PRESENT ^ (8'h01 << i)) : SIG_PRESENT;
            hit_src(i);
            release_all();
            wait_exit(i[0] ? RESET_VECTOR : BOOT_VECTOR);
        end
        sig = SIG_PRESENT;
        $display("test sources done");
    endtask

    task automatic t_disabled();
        @(posedge CLK);
        SRC_EN <= 8'h00;
        SRC_REQ[SRC_SW] <= 1'b1;
        tick(4);
        chk("masked source", 16'h0, CORE_HALT);
        release_all();
        hit_src(SRC_POR);
        release_all();
        wait_exit(BOOT_VECTOR);
        @(posedge CLK);
        SRC_EN <= 8'hFF;
        $display("test disabled done");
    endtask

    task automatic t_overlap();
        @(posedge CLK);
        SRC_REQ[SRC_WDT] <= 1'b1;
        hit_src(SRC_PIN);
        @(posedge CLK);
        SRC_REQ[SRC_PIN] <= 1'b0;
        tick(6);
        chk("held by other", 16'h1, CORE_HALT);
        chk("no early read", 16'h0, FLASH_RD);
        release_all();
        tick(2);
        hit_src(SRC_CMP);
        release_all();
        wait_exit(BOOT_VECTOR);
        $display("test overlap done");
    endtask

    task automatic t_retain();
        @(posedge CLK);
        {RET_PORT, RET_DAC, RET_VREF} <= 3'h7;
        {SW_PORT_LATCH, SW_PORT_OD, SW_PORT_PU} <= 24'h5A0F33;
        SW_DAC <= 12'hABC;
        SW_VREF <= 2'h2;
        tick(4);
        hit_src(SRC_WDT);
        chk("kept latch", 16'h5A, PORT_LATCH);
        chk("kept open drain", 16'h0F, PORT_OD);
        chk("kept pull up", 16'h33, PORT_PU);
        chk("kept dac", 16'hABC, DAC_OUT);
        chk("kept vref", 16'h2, VREF_SEL);
        release_all();
        wait_exit(BOOT_VECTOR);
        @(posedge CLK);
        {RET_PORT, RET_DAC, RET_VREF} <= 3'h0;
        tick(3);
        hit_src(SRC_SW);
        chk("latch", PORT_LATCH_R, PORT_LATCH);
        chk("open drain", PORT_OD_R, PORT_OD);
        chk("dac", DAC_R, DAC_OUT);
        release_all();
        wait_exit(BOOT_VECTOR);
        @(posedge CLK);
        {RET_PORT, RET_DAC, RET_VREF} <= 3'h7;
        tick(3);
        hit_src(SRC_POR);
        chk("por latch", PORT_LATCH_R, PORT_LATCH);
        chk("por dac", DAC_R, DAC_OUT);
        chk("por vref", VREF_R, VREF_SEL);
        release_all();
        wait_exit(BOOT_VECTOR);
        $display("test retain done");
    endtask

    // Reset input mid-run counts as power-on, so retention is ignored
    task automatic t_rst_mid();
        @(posedge CLK);
        RST_N <= 1'b0;
        tick(2);
        chk("reset latch", PORT_LATCH_R, PORT_LATCH);
        chk("reset dac", DAC_R, DAC_OUT);
        chk("reset halt", 16'h1, CORE_HALT);
        chk("reset pin drive", 16'h1, EXT_RESET_PIN_N_OE);
        chk("reset interval", WDT_IVL_MAX, WDT_IVL);
        @(posedge CLK);
        RST_N <= 1'b1;
        wait_exit(BOOT_VECTOR);
        $display("test rst_mid done");
    endtask

    initial
    begin
        CLK = 1'b0;
        RST_N = 1'b0;
        SRC_REQ = 8'h00;
        SRC_EN = 8'hFF;
        {RET_PORT, RET_DAC, RET_VREF} = 3'h0;
        {SW_PORT_LATCH, SW_PORT_OD, SW_PORT_PU} = 24'hC3C3C3;
        SW_DAC = 12'h123;
        SW_VREF = 2'h1;
        sig = SIG_PRESENT;
        failures = 0;
        num_checks = 0;
        t_power_on();
        t_sources();
        t_disabled();
        t_overlap();
        t_retain();
        t_rst_mid();
        give_verdict();
    end
endmodule
`default_nettype wire
